/* File: tco_buf2.sv */
module tco_buf2 (
	input wire logic sys_clk,
	input wire logic rst,
	tco_stream_if.snk up,
	tco_stream_if.src dn
);
	// ----------------------------------------
	// two-entry buffer, head feeds the output
	// ----------------------------------------
	logic h_v_reg;
	logic t_v_reg;
	logic [8:0] h_d_reg;
	logic [8:0] t_d_reg;

	wire push = up.valid & ~t_v_reg;
	wire pop = h_v_reg & dn.ready;
	wire [8:0] in_w = {up.last, up.data};
	wire h_load_tail = pop & t_v_reg;
	wire h_load_in = push & (~h_v_reg | pop);
	wire t_load_in = push & h_v_reg & ~pop;
	wire h_v_next = h_load_tail | h_load_in | (h_v_reg & ~pop);
	wire t_v_next = t_load_in | (t_v_reg & ~pop);
	wire [8:0] h_d_next = h_load_tail ? t_d_reg : (h_load_in ? in_w : h_d_reg);
	wire [8:0] t_d_next = t_load_in ? in_w : t_d_reg;

	// full only when the tail is taken, so a stalled sink blocks the source
	assign up.ready = ~t_v_reg;
	assign dn.valid = h_v_reg;
	assign dn.data = h_d_reg[7:0];
	assign dn.last = h_d_reg[8];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			h_v_reg <= 1'b0;
			t_v_reg <= 1'b0;
			h_d_reg <= 9'h000;
			t_d_reg <= 9'h000;
		end else begin
			h_v_reg <= h_v_next;
			t_v_reg <= t_v_next;
			h_d_reg <= h_d_next;
			t_d_reg <= t_d_next;
		end
	end

	AST_HOLD_STALL: assert property (@(posedge sys_clk) disable iff (rst)
		(dn.valid & ~dn.ready) |=> (dn.valid && $stable(dn.data) && $stable(dn.last)))
		else $error("buffer head changed while stalled");

endmodule

/* File: tco_defs.svh */
`ifndef TCO_DEFS_SVH
`define TCO_DEFS_SVH

// ----------------------------------------
// frame store
// ----------------------------------------
`define TCO_FRAME_BYTES 1536
`define TCO_FRAME_CAP 11'h600
`define TCO_IDX_ZERO 11'h000
`define TCO_IDX_ONE 11'h001

// ----------------------------------------
// command parameter word layout
// ----------------------------------------
`define TCO_DESC_HI 15
`define TCO_DESC_LO 8
`define TCO_THR_HI 7
`define TCO_THR_LO 0
`define TCO_THR_MIN 8'h01
`define TCO_THR_MAX 8'hE0

// ----------------------------------------
// frame layout, byte positions
// ----------------------------------------
`define TCO_ETYPE_LO 11'h00D
`define TCO_INNER_LO 11'h011
`define TCO_IP_OFF_PLAIN 8'h0E
`define TCO_IP_OFF_VLAN 8'h12
`define TCO_TYPE_VLAN 16'h8100
`define TCO_TYPE_IPV4 16'h0800
`define TCO_IP_LEN_LO 11'h003
`define TCO_IP_PROTO 11'h009
`define TCO_IP_CSUM_HI 11'h00A
`define TCO_IP_CSUM_LO 11'h00B
`define TCO_TCP_CSUM 11'h010
`define TCO_UDP_CSUM 11'h006
`define TCO_PROTO_TCP 8'h06
`define TCO_PROTO_UDP 8'h11

// ----------------------------------------
// checksum constants
// ----------------------------------------
`define TCO_SUM_ZERO 16'h0000
`define TCO_SUM_ONES 16'hFFFF

`endif

/* File: tco_host_sink.sv */
module tco_host_sink (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] stall_level,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// backpressure
	// --------
	// level 3 also holds each choice for 7 cycles, so the output buffer fills up
	int seed = 32'hc03be1bd;
	int hold = 0;
	initial out_ready = 1'h0;
	always @(posedge sys_clk) begin
		if (rst) begin
			out_ready <= 1'h0;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end else begin
			out_ready <= (($random(seed) & 3) >= stall_level);
			if (stall_level == 2'h3) begin
				hold <= 6;
			end
		end
	end
endmodule

/* File: tco_offload.sv */
module tco_offload (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic extended_mode,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [15:0] cmd_param_word,
	input wire logic segmentation_enable,
	input wire logic ip_header_sum_enable,
	input wire logic transport_sum_enable,
	input wire logic transport_protocol_select,
	input wire logic autonomous_parse,
	input wire logic [7:0] network_header_position,
	input wire logic [7:0] transport_header_position,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output logic out_last,
	output logic [7:0] descriptor_count,
	output logic [7:0] tx_threshold,
	output logic threshold_in_range,
	output logic [15:0] segment_payload_limit,
	output logic [15:0] ip_checksum,
	output logic [15:0] transport_checksum
);
	`include "tco_defs.svh"

	function automatic logic [15:0] tco_eac(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// ----------------------------------------
	// state and latched command
	// ----------------------------------------
	tco_pkg::tco_state_t state_reg;
	tco_pkg::tco_state_t state_next;
	logic cmd_ready_reg;
	logic in_ready_reg;
	logic seg_reg;
	logic ip_en_reg;
	logic tp_en_reg;
	logic hw_reg;
	logic tp_sel_reg;
	logic [7:0] net_pos_reg;
	logic [7:0] tp_pos_reg;
	logic [7:0] desc_reg;
	logic [7:0] thr_reg;
	logic thr_ok_reg;
	logic [15:0] seg_limit_reg;
	logic [15:0] ip_cs_reg;
	logic [15:0] tp_cs_reg;

	// per-frame parse state
	tco_pkg::tco_idx_t wr_idx_reg;
	tco_pkg::tco_idx_t rd_idx_reg;
	tco_pkg::tco_idx_t len_reg;
	logic [7:0] prev_reg;
	logic vlan_seen_reg;
	logic eth_ok_reg;
	logic ip_seen_reg;
	logic tot_seen_reg;
	logic [5:0] ihl4_reg;
	logic [15:0] tot_len_reg;
	logic [7:0] proto_reg;
	tco_pkg::tco_sum_t ip_sum_reg;
	tco_pkg::tco_sum_t tp_sum_reg;
	logic [7:0] frame_mem [0:`TCO_FRAME_BYTES-1];

	tco_stream_if push_if();
	tco_stream_if pop_if();

	wire accept_cmd = cmd_ready_reg & cmd_valid;
	wire take = in_ready_reg & in_valid;
	wire room = wr_idx_reg != `TCO_FRAME_CAP;
	wire in_recv = state_reg == tco_pkg::tco_st_recv;
	wire in_patch = state_reg == tco_pkg::tco_st_patch;
	wire in_send = state_reg == tco_pkg::tco_st_send;
	wire push_fire = push_if.valid & push_if.ready;
	wire rd_last = rd_idx_reg == (len_reg - `TCO_IDX_ONE);

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire ext_seg = extended_mode & segmentation_enable;
	wire [7:0] desc_in = cmd_param_word[`TCO_DESC_HI:`TCO_DESC_LO];
	wire [7:0] thr_in = cmd_param_word[`TCO_THR_HI:`TCO_THR_LO];
	wire thr_in_ok = (thr_in >= `TCO_THR_MIN) & (thr_in <= `TCO_THR_MAX);
	wire ip_en_in = extended_mode & ip_header_sum_enable;
	wire tp_en_in = extended_mode & transport_sum_enable;
	wire hw_in = extended_mode & autonomous_parse;
	// driver offsets only read when parsing is driver-directed and a sum needs them
	wire use_net_pos = ~hw_in & (ip_en_in | tp_en_in);
	wire use_tp_pos = ~hw_in & tp_en_in;

	// ----------------------------------------
	// header location
	// ----------------------------------------
	// offsets index the stored bytes, so a VLAN tag moves the autonomous IP offset from 0x0E to 0x12
	wire [7:0] hw_ip_off = vlan_seen_reg ? `TCO_IP_OFF_VLAN : `TCO_IP_OFF_PLAIN;
	wire [7:0] ip_off = hw_reg ? hw_ip_off : net_pos_reg;
	wire [10:0] ip_off11 = {3'h0, ip_off};
	wire [10:0] ip_end = ip_off11 + {5'h00, ihl4_reg};
	wire [10:0] tp_off11 = hw_reg ? ip_end : {3'h0, tp_pos_reg};
	wire [16:0] tp_end = {9'h000, ip_off} + {1'b0, tot_len_reg};
	wire at_ip = wr_idx_reg == ip_off11;
	wire at_len = wr_idx_reg == (ip_off11 + `TCO_IP_LEN_LO);
	wire at_proto = wr_idx_reg == (ip_off11 + `TCO_IP_PROTO);
	wire ip_cs_byte = (wr_idx_reg == (ip_off11 + `TCO_IP_CSUM_HI))
		| (wr_idx_reg == (ip_off11 + `TCO_IP_CSUM_LO));
	wire in_ip_hdr = at_ip | (ip_seen_reg & (wr_idx_reg > ip_off11) & (wr_idx_reg < ip_end));
	wire in_tp = (wr_idx_reg >= tp_off11) & ({6'h00, wr_idx_reg} < tp_end);
	wire [15:0] type_word = {prev_reg, in_data};
	wire proto_tcp = proto_reg == `TCO_PROTO_TCP;
	wire proto_udp = proto_reg == `TCO_PROTO_UDP;
	wire is_tcp = hw_reg ? proto_tcp : tp_sel_reg;
	wire ip_valid = ~hw_reg | eth_ok_reg;
	wire tp_kind_ok = ~hw_reg | proto_tcp | proto_udp;
	wire ip_do = ip_en_reg & ip_valid & ip_seen_reg;
	wire tp_do = tp_en_reg & ip_valid & tp_kind_ok & ip_seen_reg & tot_seen_reg;

	// ----------------------------------------
	// byte-wise accumulation
	// ----------------------------------------
	// byte parity against the header start decides the lane within the word
	wire ip_par = wr_idx_reg[0] ^ ip_off[0];
	wire tp_par = wr_idx_reg[0] ^ tp_off11[0];
	wire [15:0] ip_word = ip_par ? {8'h00, in_data} : {in_data, 8'h00};
	wire [15:0] tp_word = tp_par ? {8'h00, in_data} : {in_data, 8'h00};
	// the stored checksum field counts as zero while summing
	wire ip_acc = take & ip_en_reg & ip_valid & in_ip_hdr & ~ip_cs_byte;
	// preloaded pseudo-header sum in the field is summed as it stands
	wire tp_acc = take & tp_do & in_tp;
	wire [15:0] ip_sum_next = ip_acc ? tco_eac(ip_sum_reg, ip_word) : ip_sum_reg;
	wire [15:0] tp_sum_next = tp_acc ? tco_eac(tp_sum_reg, tp_word) : tp_sum_reg;

	// ----------------------------------------
	// results
	// ----------------------------------------
	wire [15:0] ip_final = ~ip_sum_reg;
	wire [15:0] tp_raw = ~tp_sum_reg;
	wire [15:0] tp_final = (~is_tcp & (tp_raw == `TCO_SUM_ZERO)) ? `TCO_SUM_ONES : tp_raw;
	wire [10:0] ip_cs_hi = ip_off11 + `TCO_IP_CSUM_HI;
	wire [10:0] ip_cs_lo = ip_off11 + `TCO_IP_CSUM_LO;
	wire [10:0] tp_cs_hi = tp_off11 + (is_tcp ? `TCO_TCP_CSUM : `TCO_UDP_CSUM);
	wire [10:0] tp_cs_lo = tp_cs_hi + `TCO_IDX_ONE;

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	// store and forward: release starts only after the patch cycle has written each enabled field
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			tco_pkg::tco_st_idle: state_next = accept_cmd ? tco_pkg::tco_st_recv : state_reg;
			tco_pkg::tco_st_recv: state_next = (take & in_last) ? tco_pkg::tco_st_patch : state_reg;
			tco_pkg::tco_st_patch: state_next = tco_pkg::tco_st_send;
			tco_pkg::tco_st_send: state_next = (push_fire & rd_last) ? tco_pkg::tco_st_idle : state_reg;
			default: state_next = tco_pkg::tco_st_idle;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= tco_pkg::tco_st_idle;
			cmd_ready_reg <= 1'b0;
			in_ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_ready_reg <= state_next == tco_pkg::tco_st_idle;
			in_ready_reg <= state_next == tco_pkg::tco_st_recv;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seg_reg <= 1'b0;
			ip_en_reg <= 1'b0;
			tp_en_reg <= 1'b0;
			hw_reg <= 1'b0;
			tp_sel_reg <= 1'b0;
			net_pos_reg <= 8'h00;
			tp_pos_reg <= 8'h00;
		end else if (accept_cmd) begin
			seg_reg <= ext_seg;
			ip_en_reg <= ip_en_in;
			tp_en_reg <= tp_en_in;
			hw_reg <= hw_in;
			tp_sel_reg <= use_tp_pos & transport_protocol_select;
			net_pos_reg <= use_net_pos ? network_header_position : 8'h00;
			tp_pos_reg <= use_tp_pos ? transport_header_position : 8'h00;
		end
	end

	// the shared word means one thing or the other, never both
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			desc_reg <= 8'h00;
			thr_reg <= 8'h00;
			thr_ok_reg <= 1'b0;
			seg_limit_reg <= 16'h0000;
		end else if (accept_cmd) begin
			desc_reg <= (extended_mode & ~ext_seg) ? desc_in : 8'h00;
			thr_reg <= (extended_mode & ~ext_seg) ? thr_in : 8'h00;
			thr_ok_reg <= extended_mode & ~ext_seg & thr_in_ok;
			seg_limit_reg <= ext_seg ? cmd_param_word : 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst | accept_cmd) begin
			wr_idx_reg <= `TCO_IDX_ZERO;
			prev_reg <= 8'h00;
			vlan_seen_reg <= 1'b0;
			eth_ok_reg <= 1'b0;
			ip_seen_reg <= 1'b0;
			tot_seen_reg <= 1'b0;
			ihl4_reg <= 6'h00;
			tot_len_reg <= 16'h0000;
			proto_reg <= 8'h00;
			ip_sum_reg <= `TCO_SUM_ZERO;
			tp_sum_reg <= `TCO_SUM_ZERO;
		end else if (take) begin
			// overflowing bytes are dropped; the frame length saturates
			wr_idx_reg <= room ? wr_idx_reg + `TCO_IDX_ONE : wr_idx_reg;
			prev_reg <= in_data;
			vlan_seen_reg <= (wr_idx_reg == `TCO_ETYPE_LO) ? (type_word == `TCO_TYPE_VLAN)
				: vlan_seen_reg;
			eth_ok_reg <= ((wr_idx_reg == `TCO_ETYPE_LO)
				| (vlan_seen_reg & (wr_idx_reg == `TCO_INNER_LO)))
				? (type_word == `TCO_TYPE_IPV4) : eth_ok_reg;
			ip_seen_reg <= ip_seen_reg | at_ip;
			ihl4_reg <= (at_ip & ~ip_seen_reg) ? {in_data[3:0], 2'b00} : ihl4_reg;
			tot_seen_reg <= tot_seen_reg | (ip_seen_reg & at_len);
			tot_len_reg <= (ip_seen_reg & at_len) ? type_word : tot_len_reg;
			proto_reg <= (ip_seen_reg & at_proto) ? in_data : proto_reg;
			ip_sum_reg <= ip_sum_next;
			tp_sum_reg <= tp_sum_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (take & room) begin
			frame_mem[wr_idx_reg] <= in_data;
		end
		if (in_patch & ip_do) begin
			frame_mem[ip_cs_hi] <= ip_final[15:8];
			frame_mem[ip_cs_lo] <= ip_final[7:0];
		end
		if (in_patch & tp_do) begin
			frame_mem[tp_cs_hi] <= tp_final[15:8];
			frame_mem[tp_cs_lo] <= tp_final[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			len_reg <= `TCO_IDX_ZERO;
			rd_idx_reg <= `TCO_IDX_ZERO;
			ip_cs_reg <= `TCO_SUM_ZERO;
			tp_cs_reg <= `TCO_SUM_ZERO;
		end else begin
			len_reg <= in_patch ? wr_idx_reg : len_reg;
			rd_idx_reg <= in_send ? (push_fire ? rd_idx_reg + `TCO_IDX_ONE : rd_idx_reg)
				: `TCO_IDX_ZERO;
			ip_cs_reg <= (in_patch & ip_do) ? ip_final : ip_cs_reg;
			tp_cs_reg <= (in_patch & tp_do) ? tp_final : tp_cs_reg;
		end
	end

	// ----------------------------------------
	// release path
	// ----------------------------------------
	assign push_if.valid = in_send;
	assign push_if.data = frame_mem[rd_idx_reg];
	assign push_if.last = rd_last;
	assign pop_if.ready = out_ready;

	tco_buf2 u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.up(push_if),
		.dn(pop_if)
	);

	assign out_valid = pop_if.valid;
	assign out_data = pop_if.data;
	assign out_last = pop_if.last;
	assign cmd_ready = cmd_ready_reg;
	assign in_ready = in_ready_reg;
	assign descriptor_count = desc_reg;
	assign tx_threshold = thr_reg;
	assign threshold_in_range = thr_ok_reg;
	assign segment_payload_limit = seg_limit_reg;
	assign ip_checksum = ip_cs_reg;
	assign transport_checksum = tp_cs_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_PARAM_SPLIT: assert property (@(posedge sys_clk) disable iff (rst)
		(accept_cmd & extended_mode & ~segmentation_enable) |=>
		(descriptor_count == $past(cmd_param_word[15:8]))
		&& (tx_threshold == $past(cmd_param_word[7:0])) && (segment_payload_limit == 16'h0000))
		else $error("parameter word split wrong");
	AST_SEG_WORD: assert property (@(posedge sys_clk) disable iff (rst)
		(accept_cmd & extended_mode & segmentation_enable) |=>
		(segment_payload_limit == $past(cmd_param_word)) && (descriptor_count == 8'h00))
		else $error("payload limit not taken");
	AST_EXT_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		(accept_cmd & ~extended_mode) |=> (!ip_en_reg && !tp_en_reg && !hw_reg))
		else $error("offload honoured outside extended mode");
	AST_HW_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
		(accept_cmd & autonomous_parse) |=> (net_pos_reg == 8'h00) && (tp_sel_reg == 1'b0))
		else $error("driver offset used under autonomous parsing");
	AST_DRV_POS: assert property (@(posedge sys_clk) disable iff (rst)
		(accept_cmd & extended_mode & ~autonomous_parse & transport_sum_enable) |=>
		(net_pos_reg == $past(network_header_position))
		&& (tp_pos_reg == $past(transport_header_position)))
		else $error("driver offsets not captured");
	AST_UDP_ONES: assert property (@(posedge sys_clk) disable iff (rst)
		(in_patch & tp_do & ~is_tcp) |=> (transport_checksum != 16'h0000))
		else $error("udp zero not mapped to ones");
	AST_IP_RESULT: assert property (@(posedge sys_clk) disable iff (rst)
		(in_patch & ip_do) |=> (ip_checksum == ~$past(ip_sum_reg)))
		else $error("ip checksum not complement of sum");
	AST_HOLD_FRAME: assert property (@(posedge sys_clk) disable iff (rst)
		(in_recv & take & in_last) |=> in_patch ##1 (in_send && rd_idx_reg == 11'h000))
		else $error("frame released before patching");
	AST_THRESH: assert property (@(posedge sys_clk) disable iff (rst)
		accept_cmd |=> (threshold_in_range == ((tx_threshold >= 8'h01) && (tx_threshold <= 8'hE0)
		&& !seg_reg && tx_threshold == $past(thr_in & {8{extended_mode & ~ext_seg}}))))
		else $error("threshold range flag wrong");
	AST_EAC: assert property (@(posedge sys_clk) disable iff (rst)
		ip_acc |=> (ip_sum_reg != 16'h0000) || ($past(ip_sum_reg) == 16'h0000 && $past(ip_word) == 16'h0000))
		else $error("end-around sum lost a carry");

	COV_TCP: cover property (@(posedge sys_clk) disable iff (rst) in_patch & tp_do & is_tcp);
	COV_UDP: cover property (@(posedge sys_clk) disable iff (rst) in_patch & tp_do & ~is_tcp);
	COV_HW_VLAN: cover property (@(posedge sys_clk) disable iff (rst) in_patch & hw_reg & vlan_seen_reg & ip_do);
	COV_STALL: cover property (@(posedge sys_clk) disable iff (rst) in_send & ~push_if.ready);

endmodule

/* File: tco_pkg.sv */
package tco_pkg;

	typedef enum logic [3:0] {
		tco_st_idle = 4'h1,
		tco_st_recv = 4'h2,
		tco_st_patch = 4'h4,
		tco_st_send = 4'h8
	} tco_state_t;

	typedef logic [10:0] tco_idx_t;
	typedef logic [15:0] tco_sum_t;

endpackage

/* File: tco_stream_if.sv */
interface tco_stream_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface

/* File: testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// stimulus and design
	// --------
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic ext = 1'h0, cmd_valid = 1'h0, seg = 1'h0, ipen = 1'h0, tpen = 1'h0;
	logic psel = 1'h0, autop = 1'h0, in_valid = 1'h0, in_last = 1'h0, sending = 1'h0;
	logic [15:0] word = 16'h0000;
	logic [7:0] nhp = 8'h00, thp = 8'h00, in_data = 8'h00;
	logic cmd_ready, in_ready, out_valid, out_ready, out_last, thr_ok;
	logic [7:0] out_data, dcnt, thr;
	logic [15:0] pay_lim, ip_cs, tp_cs;
	logic [15:0] exp_ip = 16'h0000, exp_tp = 16'h0000;
	logic [1:0] stall = 2'h0;
	logic [7:0] fr[$];
	logic [8:0] exp_q[$];
	logic [31:0] r;
	int seed = 32'hc03be1bd;
	int mismatches = 0;
	int check_count = 0;

	always #10 sys_clk = ~sys_clk;

	tco_offload i_dut (.sys_clk(sys_clk), .rst(rst), .extended_mode(ext),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_param_word(word),
		.segmentation_enable(seg), .ip_header_sum_enable(ipen), .transport_sum_enable(tpen),
		.transport_protocol_select(psel), .autonomous_parse(autop),
		.network_header_position(nhp), .transport_header_position(thp),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_last(in_last),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
		.descriptor_count(dcnt), .tx_threshold(thr), .threshold_in_range(thr_ok),
		.segment_payload_limit(pay_lim), .ip_checksum(ip_cs), .transport_checksum(tp_cs));
	tco_host_sink i_sink (.sys_clk(sys_clk), .rst(rst), .stall_level(stall),
		.out_ready(out_ready));

	// --------
	// checking helpers
	// --------
	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// sampled at the falling edge, where the flag has settled
	task automatic wait_hi(ref logic s, input int lim);
		int n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				mismatches++;
				print_verdict();
			end
		end while (s !== 1'h1);
	endtask

	function automatic logic [15:0] ocsum(input int a, input int b);
		logic [16:0] s;
		s = 17'h00000;
		for (int i = a; i <= b; i += 2) begin
			s = s[15:0] + {fr[i], (i < b) ? fr[i + 1] : 8'h00};
			s = s[15:0] + s[16];
		end
		return s[15:0];
	endfunction

	always @(posedge sys_clk) begin
		if (!rst && out_valid === 1'h1 && out_ready === 1'h1) begin
			if (exp_q.size() == 0)
				chk("extra_byte", 17'h00000, 17'h1FFFF);
			else
				chk("out_byte", exp_q.pop_front(), {out_last, out_data});
		end
		if (!rst && sending && out_valid !== 1'h0)
			chk("early_out", 17'h00000, 17'h00001);
	end

	task automatic run_frame(input logic e, sg, ip, tp, ps, au, vl, input int ihl, tl,
		input logic tcp, zr, input logic [15:0] w);
		int io, to, n;
		logic [15:0] c;
		logic [7:0] src[$];
		fr.delete();
		repeat (12) fr.push_back(8'($random(seed)));
		if (vl)
			fr = {fr, 8'h81, 8'h00, 8'($random(seed)), 8'h05};
		fr = {fr, 8'h08, 8'h00};
		io = fr.size();
		to = io + 4 * ihl;
		// random transport field stands for the preloaded pseudo-header sum
		repeat (4 * ihl + tl + 2) fr.push_back(8'($random(seed)));
		fr[io] = {4'h4, 4'(ihl)};
		{fr[io + 2], fr[io + 3]} = 16'(4 * ihl + tl);
		{fr[io + 6], fr[io + 7]} = 16'h0000;
		fr[io + 9] = tcp ? 8'h06 : 8'h11;
		if (zr) begin
			{fr[to + tl - 2], fr[to + tl - 1]} = 16'h0000;
			{fr[to + tl - 2], fr[to + tl - 1]} = ~ocsum(to, to + tl - 1);
		end
		src = fr;
		if (e && ip) begin
			{fr[io + 10], fr[io + 11]} = 16'h0000;
			exp_ip = ~ocsum(io, to - 1);
			{fr[io + 10], fr[io + 11]} = exp_ip;
		end
		if (e && tp) begin
			c = ~ocsum(to, to + tl - 1);
			if (!tcp && c == 16'h0000)
				c = 16'hFFFF;
			n = to + (tcp ? 16 : 6);
			{fr[n], fr[n + 1]} = c;
			exp_tp = c;
		end
		foreach (fr[i]) exp_q.push_back({i == fr.size() - 1, fr[i]});
		@(posedge sys_clk);
		{ext, seg, ipen, tpen, psel, autop, word} <= {e, sg, ip, tp, ps, au, w};
		nhp <= au ? 8'($random(seed)) : 8'(io);
		thp <= au ? 8'($random(seed)) : 8'(to);
		cmd_valid <= 1'h1;
		wait_hi(cmd_ready, 20);
		@(posedge sys_clk);
		cmd_valid <= 1'h0;
		@(negedge sys_clk);
		chk("desc_count", (e && !sg) ? w[15:8] : 8'h00, dcnt);
		chk("threshold", (e && !sg) ? w[7:0] : 8'h00, thr);
		chk("thr_range", e && !sg && w[7:0] >= 8'h01 && w[7:0] <= 8'hE0, thr_ok);
		chk("pay_limit", (e && sg) ? w : 16'h0000, pay_lim);
		foreach (src[i]) begin
			if ($random(seed) % 5 == 0) begin
				@(posedge sys_clk);
				in_valid <= 1'h0;
			end
			@(posedge sys_clk);
			sending <= 1'h1;
			in_valid <= 1'h1;
			in_data <= src[i];
			in_last <= i == src.size() - 1;
			wait_hi(in_ready, 20);
		end
		@(posedge sys_clk);
		{in_valid, in_last, sending} <= 3'h0;
		wait_hi(cmd_ready, 3000);
		chk("ip_sum", exp_ip, ip_cs);
		chk("tp_sum", exp_tp, tp_cs);
		n = 0;
		while (exp_q.size() > 0) begin
			@(negedge sys_clk);
			n++;
			if (n > 3000)
				chk("drain", 17'h00000, 17'(exp_q.size()));
			if (n > 3000)
				print_verdict();
		end
	endtask

	// --------
	// scenarios
	// --------
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		run_frame(1, 0, 1, 1, 0, 0, 0, 5, 30, 0, 1, 16'h0400);
		stall = 2'h3;
		run_frame(1, 0, 1, 1, 1, 0, 1, 6, 41, 1, 0, 16'h0201);
		stall = 2'h1;
		run_frame(1, 1, 1, 1, 0, 1, 1, 5, 40, 1, 0, 16'h05DC);
		run_frame(1, 0, 0, 1, 1, 1, 0, 7, 27, 0, 0, 16'h07E0);
		run_frame(1, 0, 1, 0, 0, 0, 0, 5, 20, 1, 0, 16'hE1FF);
		run_frame(0, 0, 1, 1, 1, 0, 0, 5, 24, 1, 0, 16'h1234);
		@(posedge sys_clk);
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		{exp_ip, exp_tp} = 32'h00000000;
		@(negedge sys_clk);
		chk("rst_ip_sum", 17'h00000, ip_cs);
		repeat (5) begin
			r = $random(seed);
			stall = r[13:12];
			run_frame(1, r[0], r[1], r[2], r[3], 1, r[4], 5 + r[6:5], 20 + r[10:7], r[11], 0,
				r[31:16]);
		end
		print_verdict();
	end
endmodule
